// ---- hdl/mhp_pkg.sv ----
package mhp_pkg;

  // ---------------------------------------------------------------
  // Clocks and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ = 100_000;
  // Reference frequency the crystal pins carry; used only by the testbench reference generator.
  localparam int unsigned REF_FREQ_KHZ = 9_600;
  localparam int unsigned MIDI_BAUD = 31_250;
  localparam int unsigned BIT_CYCLES = (CLK_FREQ_KHZ * 1000) / MIDI_BAUD;
  localparam int unsigned HALF_BIT_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned BIT_CNT_W = 12;
  localparam int unsigned INIT_TIME_MS = 50;
  localparam int unsigned INIT_CYCLES = INIT_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned INIT_CNT_W = 23;

  // ---------------------------------------------------------------
  // Host port encodings
  // ---------------------------------------------------------------
  typedef logic [7:0] mhp_byte_t;
  localparam logic REG_SEL_DATA = 1'b0;
  localparam logic REG_SEL_CTRL = 1'b1;
  localparam mhp_byte_t CMD_PORT_RESET = 8'hff;
  localparam mhp_byte_t CMD_UART_MODE = 8'h3f;
  localparam int unsigned STAT_RX_EMPTY_BIT = 7;
  localparam int unsigned STAT_TX_BUSY_BIT = 6;
  localparam logic UART_MODE_RESET = 1'b0;
  localparam mhp_byte_t BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Serial receiver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MHP_RX_IDLE = 2'b00,
    MHP_RX_START = 2'b01,
    MHP_RX_DATA = 2'b10,
    MHP_RX_STOP = 2'b11
  } mhp_rx_state_e;

endpackage

// ---- hdl/mhp_rx_if.sv ----
`timescale 1ns/1ps
interface mhp_rx_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic rx_enable;
  modport rcv (input rx_enable, output rx_byte, output rx_valid);
  modport host (output rx_enable, input rx_byte, input rx_valid);
endinterface

// ---- hdl/mhp_serial_rx.sv ----
`timescale 1ns/1ps
module mhp_serial_rx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic serial_in,
  mhp_rx_if.rcv rx
);
  import mhp_pkg::*;

  mhp_rx_state_e state_r, state_nxt;
  logic [BIT_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic valid_r, valid_nxt;
  wire tick_w = (cnt_r == '0);

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  // The start bit is checked again at mid-bit so a glitch is not taken
  // as a frame; a bad stop bit drops the byte silently.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = tick_w ? cnt_r : cnt_r - 1'b1;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    valid_nxt = 1'b0;
    case (state_r)
      MHP_RX_IDLE: begin
        if (!serial_in) begin
          state_nxt = MHP_RX_START;
          cnt_nxt = BIT_CNT_W'(HALF_BIT_CYCLES - 1);
        end
      end
      MHP_RX_START: begin
        if (tick_w) begin
          state_nxt = serial_in ? MHP_RX_IDLE : MHP_RX_DATA;
          cnt_nxt = BIT_CNT_W'(BIT_CYCLES - 1);
          bit_nxt = 3'd0;
        end
      end
      MHP_RX_DATA: begin
        if (tick_w) begin
          shift_nxt = {serial_in, shift_r[7:1]};
          cnt_nxt = BIT_CNT_W'(BIT_CYCLES - 1);
          bit_nxt = bit_r + 3'd1;
          if (bit_r == 3'd7) begin
            state_nxt = MHP_RX_STOP;
          end
        end
      end
      MHP_RX_STOP: begin
        if (tick_w) begin
          state_nxt = MHP_RX_IDLE;
          valid_nxt = serial_in;
        end
      end
      default: begin
        state_nxt = MHP_RX_IDLE;
      end
    endcase
    if (!rx.rx_enable) begin
      state_nxt = MHP_RX_IDLE;
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= MHP_RX_IDLE;
      cnt_r <= '0;
      bit_r <= 3'd0;
      shift_r <= BYTE_RESET;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign rx.rx_byte = shift_r;
  assign rx.rx_valid = valid_r;

endmodule // mhp_serial_rx

// ---- hdl/mhp_host_port.sv ----
`timescale 1ns/1ps
// What this block does
// - Register select low picks data; high picks status on read, control on write.
// - With chip select and read low, drive data or status onto the bus.
// - Read strobe rising edge means the host has taken the byte.
// - Once initialisation is done, a write strobe rising edge captures the bus into data or control.
// - A waiting serial byte is signalled by a rising byte-ready output.
// - Reading the waiting byte clears byte-ready.
// - After reset or a port reset command, serial input feeds the synthesizer.
// - In UART mode serial bytes go to the bus read path instead.
// - Eight data lines whose direction follows chip select, the read strobe and the sleep state.
// - Chip select is active low and frames the whole access.
// - Sleep request forces every output low and drops the oscillator enable.
// - Run indicator is high only while the synthesizer is operational.
// - Reset is active low; the block stays in reset while it is low.
// - The synthesizer reference is a 9.6 MHz crystal or external clock.
// - A buffered copy of the reference drives the converter master clock.
// - About 50 ms of initialisation after reset before messages are processed.
module mhp_host_port #(
  parameter int unsigned INIT_CYCLES_P = mhp_pkg::INIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select,
  input wire mhp_pkg::mhp_byte_t host_data_in,
  output mhp_pkg::mhp_byte_t host_data_out,
  output logic host_data_oe,
  output logic byte_ready,
  input wire logic serial_music_input,
  input wire logic sleep_request_n,
  input wire logic crystal_ref_in,
  output logic master_clock_out,
  output logic osc_enable,
  output logic run,
  output logic uart_mode,
  output mhp_pkg::mhp_byte_t synth_byte,
  output logic synth_byte_valid,
  output mhp_pkg::mhp_byte_t host_byte,
  output logic host_byte_valid
);
  import mhp_pkg::*;

  // ---------------------------------------------------------------
  // Power state and initialisation
  // ---------------------------------------------------------------
  // Once asleep the core stays dark until reset, since the oscillator is
  // gone and nothing in the core can be trusted to restart by itself.
  logic slept_r;
  logic init_done_r;
  logic [INIT_CNT_W-1:0] init_cnt_r;
  wire active_w = sleep_request_n && !slept_r;
  wire ready_w = active_w && init_done_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slept_r <= 1'b0;
      init_cnt_r <= '0;
      init_done_r <= 1'b0;
    end else begin
      slept_r <= slept_r || !sleep_request_n;
      if (active_w && !init_done_r) begin
        init_cnt_r <= init_cnt_r + 1'b1;
        init_done_r <= (init_cnt_r == INIT_CNT_W'(INIT_CYCLES_P - 1));
      end
    end
  end

  // ---------------------------------------------------------------
  // Strobe edges
  // ---------------------------------------------------------------
  logic rd_prev_r, wr_prev_r, cs_prev_r;
  mhp_byte_t din_prev_r;
  wire sel_prev_w;
  logic sel_prev_r;
  assign sel_prev_w = sel_prev_r;
  // The access counts only if chip select was low while the strobe was low.
  wire rd_rise_w = rd_n && !rd_prev_r && !cs_prev_r && active_w;
  wire wr_rise_w = wr_n && !wr_prev_r && !cs_prev_r && ready_w;
  wire data_ack_w = rd_rise_w && (sel_prev_w == REG_SEL_DATA);
  wire data_wr_w = wr_rise_w && (sel_prev_w == REG_SEL_DATA);
  wire ctrl_wr_w = wr_rise_w && (sel_prev_w == REG_SEL_CTRL);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_prev_r <= 1'b1;
      wr_prev_r <= 1'b1;
      cs_prev_r <= 1'b1;
      sel_prev_r <= REG_SEL_DATA;
      din_prev_r <= BYTE_RESET;
    end else begin
      rd_prev_r <= rd_n;
      wr_prev_r <= wr_n;
      cs_prev_r <= cs_n;
      sel_prev_r <= register_select;
      din_prev_r <= host_data_in;
    end
  end

  // ---------------------------------------------------------------
  // Serial input and routing
  // ---------------------------------------------------------------
  mhp_rx_if rx_bus ();
  assign rx_bus.rx_enable = ready_w;

  mhp_serial_rx u_rx (
    .clk(clk),
    .nrst(nrst),
    .serial_in(serial_music_input),
    .rx(rx_bus)
  );

  logic uart_mode_r;
  logic pending_r;
  mhp_byte_t data_r;
  wire to_bus_w = rx_bus.rx_valid && uart_mode_r;
  wire to_synth_w = rx_bus.rx_valid && !uart_mode_r;
  // A new byte in the same cycle as the ack keeps the flag set.
  wire pending_nxt = to_bus_w || (pending_r && !data_ack_w);
  wire uart_mode_nxt = (ctrl_wr_w && din_prev_r == CMD_UART_MODE) ? 1'b1 :
                       (ctrl_wr_w && din_prev_r == CMD_PORT_RESET) ? 1'b0 :
                       uart_mode_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uart_mode_r <= UART_MODE_RESET;
      pending_r <= 1'b0;
      data_r <= BYTE_RESET;
    end else begin
      uart_mode_r <= active_w ? uart_mode_nxt : UART_MODE_RESET;
      pending_r <= active_w && pending_nxt;
      if (to_bus_w) begin
        data_r <= rx_bus.rx_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus read path and outputs
  // ---------------------------------------------------------------
  mhp_byte_t status_w;
  always_comb begin
    status_w = BYTE_RESET;
    status_w[STAT_RX_EMPTY_BIT] = !pending_r;
    status_w[STAT_TX_BUSY_BIT] = !ready_w;
  end
  wire read_on_w = !cs_n && !rd_n && active_w;
  wire [7:0] rd_mux_w = (register_select == REG_SEL_CTRL) ? status_w : data_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_data_out <= BYTE_RESET;
      host_data_oe <= 1'b0;
      byte_ready <= 1'b0;
      master_clock_out <= 1'b0;
      osc_enable <= 1'b0;
      run <= 1'b0;
      uart_mode <= 1'b0;
      synth_byte <= BYTE_RESET;
      synth_byte_valid <= 1'b0;
      host_byte <= BYTE_RESET;
      host_byte_valid <= 1'b0;
    end else begin
      host_data_oe <= read_on_w;
      host_data_out <= read_on_w ? rd_mux_w : BYTE_RESET;
      byte_ready <= active_w && pending_nxt;
      master_clock_out <= active_w && crystal_ref_in;
      osc_enable <= active_w;
      run <= ready_w;
      uart_mode <= active_w && uart_mode_nxt;
      synth_byte_valid <= active_w && to_synth_w;
      synth_byte <= (active_w && to_synth_w) ? rx_bus.rx_byte : BYTE_RESET;
      host_byte_valid <= data_wr_w;
      host_byte <= data_wr_w ? din_prev_r : BYTE_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_READ_DRIVE: assert property (@(posedge clk) disable iff (!nrst)
    (!cs_n && !rd_n && active_w) |=> host_data_oe)
    else $error("bus not driven during read");
  AST_CS_IDLE: assert property (@(posedge clk) disable iff (!nrst)
    cs_n |=> !host_data_oe)
    else $error("bus driven without chip select");
  AST_STATUS_READ: assert property (@(posedge clk) disable iff (!nrst)
    (read_on_w && register_select) |=> (host_data_out == $past(status_w)))
    else $error("status register not presented");
  AST_UART_CMD: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_wr_w && din_prev_r == CMD_UART_MODE && active_w) |=> uart_mode_r)
    else $error("uart mode command not taken");
  AST_PORT_RESET: assert property (@(posedge clk) disable iff (!nrst)
    (ctrl_wr_w && din_prev_r == CMD_PORT_RESET) |=> !uart_mode_r ##1 !uart_mode)
    else $error("port reset did not restore synth routing");
  AST_READY_RISE: assert property (@(posedge clk) disable iff (!nrst)
    (to_bus_w && active_w && !pending_r) |=>
      $rose(byte_ready) && data_r == $past(rx_bus.rx_byte))
    else $error("byte ready did not rise for waiting byte");
  AST_ACK_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    (data_ack_w && !rx_bus.rx_valid) |=> !byte_ready)
    else $error("byte ready not cleared by data read");
  AST_UART_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
    (rx_bus.rx_valid && uart_mode_r) |=> !synth_byte_valid)
    else $error("serial byte reached synthesizer in uart mode");
  AST_SYNTH_ROUTE: assert property (@(posedge clk) disable iff (!nrst)
    (rx_bus.rx_valid && !uart_mode_r && active_w) |=> synth_byte_valid)
    else $error("serial byte not routed to synthesizer");
  AST_SLEEP_LOW: assert property (@(posedge clk) disable iff (!nrst)
    !sleep_request_n |=> !host_data_oe && !byte_ready && !run && !osc_enable
      && !master_clock_out && host_data_out == BYTE_RESET)
    else $error("output active during sleep");
  AST_RUN_INIT: assert property (@(posedge clk) disable iff (!nrst)
    run |-> init_done_r && $past(active_w))
    else $error("run high while not operational");
  AST_MCLK_COPY: assert property (@(posedge clk) disable iff (!nrst)
    active_w |=> master_clock_out == $past(crystal_ref_in))
    else $error("master clock does not follow the reference");
  AST_DATA_WRITE: assert property (@(posedge clk) disable iff (!nrst)
    data_wr_w |=> host_byte_valid && host_byte == $past(din_prev_r))
    else $error("data write not handed over");

endmodule // mhp_host_port

// ---- testbench/mhp_host_model.sv ----
`timescale 1ns/1ps
// --------------------
// Host processor on the parallel bus
// --------------------
module mhp_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic register_select,
  output mhp_pkg::mhp_byte_t host_data_in,
  input wire mhp_pkg::mhp_byte_t host_data_out,
  input wire logic host_data_oe
);
  import mhp_pkg::*;
  logic drv;
  mhp_byte_t wdata;
  mhp_byte_t last_r = 8'h00;
  // A bus nobody drives toggles every cycle, so a stale byte never passes for a real one.
  assign host_data_in = host_data_oe ? host_data_out : (drv ? wdata : ~last_r);
  always @(posedge clk) begin
    last_r <= host_data_in;
  end
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    register_select = 1'b0;
    drv = 1'b0;
    wdata = 8'h00;
  end
  // Chip select and address frame the strobe by a full cycle on each side.
  task automatic access(input logic rd, input logic sel, input logic rs, input mhp_byte_t d,
                        input int hold, output mhp_byte_t q, output logic oe);
    @(negedge clk);
    cs_n = ~sel;
    register_select = rs;
    wdata = d;
    drv = ~rd;
    @(negedge clk);
    if (rd) begin
      rd_n = 1'b0;
    end else begin
      wr_n = 1'b0;
    end
    repeat (hold) @(negedge clk);
    q = host_data_out;
    oe = host_data_oe;
    rd_n = 1'b1;
    wr_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    drv = 1'b0;
  endtask
endmodule // mhp_host_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import mhp_pkg::*;
  typedef struct packed {logic rs; mhp_byte_t din; logic uart; logic hb;} mhp_row_s;
  logic clk, nrst, cs_n, rd_n, wr_n, register_select, serial_music_input, sleep_request_n;
  logic crystal_ref_in, host_data_oe, byte_ready, master_clock_out, osc_enable, run, uart_mode;
  logic synth_byte_valid, host_byte_valid, ref_q, oe;
  mhp_byte_t host_data_in, host_data_out, synth_byte, host_byte, last_synth, last_host, q;
  int n_fail = 0, compares = 0, synth_cnt = 0, host_cnt = 0, s0, hb0, ref_phase = 0;
  mhp_row_s rows [6] = '{'{1'b0, 8'h90, 1'b0, 1'b1}, '{1'b1, 8'h3f, 1'b1, 1'b0},
    '{1'b1, 8'h12, 1'b1, 1'b0}, '{1'b0, 8'h00, 1'b1, 1'b1}, '{1'b1, 8'hff, 1'b0, 1'b0},
    '{1'b0, 8'hff, 1'b0, 1'b1}};
  mhp_host_port #(.INIT_CYCLES_P(20)) mhp_host_port_inst (.clk(clk), .nrst(nrst), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .register_select(register_select), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .byte_ready(byte_ready),
    .serial_music_input(serial_music_input), .sleep_request_n(sleep_request_n),
    .crystal_ref_in(crystal_ref_in), .master_clock_out(master_clock_out),
    .osc_enable(osc_enable), .run(run), .uart_mode(uart_mode), .synth_byte(synth_byte),
    .synth_byte_valid(synth_byte_valid), .host_byte(host_byte),
    .host_byte_valid(host_byte_valid));
  mhp_host_model mhp_host_model_inst (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .register_select(register_select), .host_data_in(host_data_in),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The reference is stepped on falling edges by a phase accumulator, so it keeps the
  // average crystal rate yet never moves at the edge where the design samples it.
  initial begin
    crystal_ref_in = 1'b0;
    forever begin
      @(negedge clk);
      ref_phase = (ref_phase + REF_FREQ_KHZ) % CLK_FREQ_KHZ;
      crystal_ref_in = (ref_phase >= CLK_FREQ_KHZ / 2);
    end
  end
  always @(posedge clk) begin
    ref_q <= crystal_ref_in;
    if (synth_byte_valid === 1'b1) begin
      synth_cnt <= synth_cnt + 1;
      last_synth <= synth_byte;
    end
    if (host_byte_valid === 1'b1) begin
      host_cnt <= host_cnt + 1;
      last_host <= host_byte;
    end
  end
  // --------------------
  // Shared tasks
  // --------------------
  task automatic check(input string name, input mhp_byte_t seen, input mhp_byte_t exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Counts: compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk);
    nrst = 1'b0;
    repeat (5) @(negedge clk);
    check("reset_outs", {run, osc_enable, host_data_oe, byte_ready, uart_mode, synth_byte_valid,
      host_byte_valid, master_clock_out}, 8'h00);
    nrst = 1'b1;
    $display("test reset done");
  endtask
  task automatic wait_run;
    int k;
    k = 0;
    while (run !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    check("run", {7'h0, run}, 8'h01);
    check("osc_enable", {7'h0, osc_enable}, 8'h01);
  endtask
  task automatic rd_chk(input string name, input logic rs, input mhp_byte_t exp);
    mhp_host_model_inst.access(1'b1, 1'b1, rs, 8'h00, 2, q, oe);
    check(name, q, exp);
    check("oe", {7'h0, oe}, 8'h01);
  endtask
  task automatic wr(input logic sel, input logic rs, input mhp_byte_t d);
    mhp_host_model_inst.access(1'b0, sel, rs, d, 2, q, oe);
    repeat (2) @(negedge clk);
  endtask
  task automatic send_ser(input mhp_byte_t b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_music_input = f[i];
      repeat (BIT_CYCLES) @(negedge clk);
    end
    repeat (4) @(negedge clk);
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    nrst = 1'b0;
    sleep_request_n = 1'b1;
    serial_music_input = 1'b1;
    do_reset;
    rd_chk("status_init", 1'b1, 8'hc0);
    wr(1'b1, 1'b1, CMD_UART_MODE);
    check("run_init", {7'h0, run}, 8'h00);
    check("uart_init", {7'h0, uart_mode}, 8'h00);
    wait_run;
    repeat (8) begin
      @(negedge clk);
      check("mclk", {7'h0, master_clock_out}, {7'h0, ref_q});
    end
    $display("test init done");
    foreach (rows[i]) begin
      hb0 = host_cnt;
      wr(1'b1, rows[i].rs, rows[i].din);
      check("uart_mode", {7'h0, uart_mode}, {7'h0, rows[i].uart});
      check("host_cnt", 8'(host_cnt - hb0), {7'h0, rows[i].hb});
      if (rows[i].hb) check("host_byte", last_host, rows[i].din);
      rd_chk("status", 1'b1, 8'h80);
    end
    $display("test table done");
    mhp_host_model_inst.access(1'b1, 1'b0, 1'b0, 8'h00, 2, q, oe);
    check("oe_unselected", {7'h0, oe}, 8'h00);
    wr(1'b0, 1'b1, CMD_UART_MODE);
    check("uart_unselected", {7'h0, uart_mode}, 8'h00);
    $display("test unselected done");
    s0 = synth_cnt;
    send_ser(8'h5c);
    check("synth_cnt", 8'(synth_cnt - s0), 8'h01);
    check("synth_byte", last_synth, 8'h5c);
    check("ready_synth", {7'h0, byte_ready}, 8'h00);
    wr(1'b1, 1'b1, CMD_UART_MODE);
    send_ser(8'ha5);
    check("byte_ready", {7'h0, byte_ready}, 8'h01);
    check("synth_uart", 8'(synth_cnt - s0), 8'h01);
    rd_chk("status_wait", 1'b1, 8'h00);
    mhp_host_model_inst.access(1'b1, 1'b1, 1'b0, 8'h00, 6, q, oe);
    check("data_uart", q, 8'ha5);
    @(negedge clk);
    check("ready_ack", {7'h0, byte_ready}, 8'h00);
    check("oe_release", {7'h0, host_data_oe}, 8'h00);
    $display("test serial done");
    sleep_request_n = 1'b0;
    repeat (3) @(negedge clk);
    check("sleep_outs", {run, osc_enable, uart_mode, master_clock_out, host_data_oe, byte_ready,
      synth_byte_valid, host_byte_valid}, 8'h00);
    sleep_request_n = 1'b1;
    repeat (3) @(negedge clk);
    check("sleep_latched", {7'h0, run}, 8'h00);
    do_reset;
    wait_run;
    check("uart_after_reset", {7'h0, uart_mode}, 8'h00);
    $display("test sleep done");
    close_out;
  end
  // Two serial bytes dominate the run; this limit leaves ample margin above them.
  initial begin
    #900_000;
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    close_out;
  end
endmodule // tb_top
